// ### verilog/tcf_defs.vh
`ifndef TCF_DEFS_VH
`define TCF_DEFS_VH

// Register byte offsets.
`define TCF_CFG_OFFSET        8'h00
`define TCF_CTL_OFFSET        8'h0c
`define TCF_STATUS_OFFSET     8'h30

// Configuration field values.
`define TCF_CFG_WIDTH         3
`define TCF_CFG_RESET         3'h0
`define TCF_CFG_32BIT         3'h0
`define TCF_CFG_RTC           3'h1

// Control register field positions.
`define TCF_EVT_HI            11
`define TCF_EVT_LO            10
`define TCF_STALL_BIT         9
`define TCF_B_EN_BIT          8
`define TCF_RSVD_BIT          7
`define TCF_PWML_BIT          6
`define TCF_OTE_BIT           5
`define TCF_CTL_RESET         32'h00000000

// Edge select encodings.
`define TCF_EDGE_POS          2'h0
`define TCF_EDGE_NEG          2'h1
`define TCF_EDGE_RSVD         2'h2
`define TCF_EDGE_BOTH         2'h3

`endif

// ### verilog/tcf_timer_control.v
`include "tcf_defs.vh"

// Behaviour
// [RL1] Bits 11:10 pick capture edge for half B: positive, negative, both; 2 reserved.
// [RL2] Bit 9 enables half B debug stall; resets to zero.
// [RL3] Bit 8 clear disables half B; set lets it count or capture.
// [RL4] Bit 6 set inverts half A PWM output; clear passes it unchanged.
// [RL5] Bit 5 enables half A output trigger; read-write, resets to zero.
// [RL6] Bit 7 is read-only zero; software preserves it on read-modify-write.
// [RL7] Enabled output trigger pulses are routed to the converter start input.
// [RL8] Configuration picks 32-bit timer, real-time counter, or two 16-bit halves.
// [RL9] With stall enabled and processor halted, half B freezes, resumes after.
module tcf_timer_control (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire        bus_write,
    input  wire        bus_read,
    output reg  [31:0] bus_rdata,
    input  wire        debug_halt,
    input  wire        half_b_capture_pin,
    input  wire        half_a_pwm_raw,
    input  wire        half_a_trigger_raw,
    output reg         half_a_pwm_out,
    output reg         adc_trigger,
    output reg         half_b_capture_event,
    output reg         half_b_count_enable,
    output reg         half_b_capture_enable,
    output reg         split_halves
);

    reg [1:0]                 half_b_edge_select;
    reg                       half_b_debug_stall_enable;
    reg                       half_b_run_enable;
    reg                       half_a_pwm_level_invert;
    reg                       half_a_output_trigger_enable;
    reg [`TCF_CFG_WIDTH-1:0]  timer_configuration_select;
    reg                       halt_meta_reg;
    reg                       halt_sync_reg;
    reg                       cap_meta_reg;
    reg                       cap_sync_reg;
    reg                       cap_prev_reg;
    reg [31:0]                timer_control_reg;
    reg [31:0]                rdata_next;
    reg                       edge_hit;
    wire                      cap_rise;
    wire                      cap_fall;
    wire                      b_active;
    wire                      is_split;

    always @* begin
        timer_control_reg                       = `TCF_CTL_RESET;
        timer_control_reg[`TCF_EVT_HI:`TCF_EVT_LO] = half_b_edge_select;
        timer_control_reg[`TCF_STALL_BIT]       = half_b_debug_stall_enable;
        timer_control_reg[`TCF_B_EN_BIT]        = half_b_run_enable;
        timer_control_reg[`TCF_RSVD_BIT]        = 1'b0; // RL6
        timer_control_reg[`TCF_PWML_BIT]        = half_a_pwm_level_invert;
        timer_control_reg[`TCF_OTE_BIT]         = half_a_output_trigger_enable;
    end

    // Register writes; bit 7 and all bits outside the stored fields are discarded.
    always @(posedge clk) begin
        if (rst) begin
            half_b_edge_select           <= `TCF_EDGE_POS;
            half_b_debug_stall_enable    <= 1'b0;
            half_b_run_enable            <= 1'b0;
            half_a_pwm_level_invert      <= 1'b0;
            half_a_output_trigger_enable <= 1'b0;
            timer_configuration_select   <= `TCF_CFG_RESET;
        end else if (bus_write) begin
            if (bus_addr == `TCF_CTL_OFFSET) begin
                half_b_edge_select           <= bus_wdata[`TCF_EVT_HI:`TCF_EVT_LO]; // RL1
                half_b_debug_stall_enable    <= bus_wdata[`TCF_STALL_BIT]; // RL2
                half_b_run_enable            <= bus_wdata[`TCF_B_EN_BIT]; // RL3
                half_a_pwm_level_invert      <= bus_wdata[`TCF_PWML_BIT]; // RL4
                half_a_output_trigger_enable <= bus_wdata[`TCF_OTE_BIT]; // RL5
            end
            if (bus_addr == `TCF_CFG_OFFSET) begin
                timer_configuration_select <= bus_wdata[`TCF_CFG_WIDTH-1:0]; // RL8
            end
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always @* begin
        rdata_next = 32'h00000000;
        if (bus_read) begin
            case (bus_addr)
                `TCF_CFG_OFFSET:    rdata_next = {29'h0, timer_configuration_select};
                `TCF_CTL_OFFSET:    rdata_next = timer_control_reg;
                `TCF_STATUS_OFFSET: rdata_next = {28'h0, half_b_capture_event, half_b_count_enable,
                                                  half_b_capture_enable, split_halves};
                default:            rdata_next = 32'h00000000;
            endcase
        end
    end

    // Pin inputs pass two flip-flops before use.
    always @(posedge clk) begin
        if (rst) begin
            halt_meta_reg <= 1'b0;
            halt_sync_reg <= 1'b0;
            cap_meta_reg  <= 1'b0;
            cap_sync_reg  <= 1'b0;
            cap_prev_reg  <= 1'b0;
        end else begin
            halt_meta_reg <= debug_halt;
            halt_sync_reg <= halt_meta_reg;
            cap_meta_reg  <= half_b_capture_pin;
            cap_sync_reg  <= cap_meta_reg;
            cap_prev_reg  <= cap_sync_reg;
        end
    end

    assign cap_rise = cap_sync_reg & ~cap_prev_reg;
    assign cap_fall = ~cap_sync_reg & cap_prev_reg;
    // Split mode is any value with the top bit set.
    assign is_split = timer_configuration_select[2]; // RL8
    // A halted processor freezes half B only when stalling is allowed.
    assign b_active = half_b_run_enable & ~(half_b_debug_stall_enable & halt_sync_reg); // RL9

    // The reserved edge code captures nothing, so software cannot get surprise events.
    always @* begin
        case (half_b_edge_select)
            `TCF_EDGE_POS:  edge_hit = cap_rise; // RL1
            `TCF_EDGE_NEG:  edge_hit = cap_fall;
            `TCF_EDGE_BOTH: edge_hit = cap_rise | cap_fall;
            default:        edge_hit = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            bus_rdata             <= 32'h00000000;
            half_a_pwm_out        <= 1'b0;
            adc_trigger           <= 1'b0;
            half_b_capture_event  <= 1'b0;
            half_b_count_enable   <= 1'b0;
            half_b_capture_enable <= 1'b0;
            split_halves          <= 1'b0;
        end else begin
            bus_rdata             <= rdata_next;
            half_a_pwm_out        <= half_a_pwm_raw ^ half_a_pwm_level_invert; // RL4
            adc_trigger           <= half_a_trigger_raw & half_a_output_trigger_enable; // RL5 RL7
            half_b_capture_event  <= edge_hit & b_active & is_split; // RL3
            half_b_count_enable   <= b_active & is_split; // RL3 RL9
            half_b_capture_enable <= half_b_run_enable & is_split; // RL3
            split_halves          <= is_split; // RL8
        end
    end

endmodule

// ### test/tcf_timer_control_checker.sv
module tcf_timer_control_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_write,
    input wire logic        bus_read,
    input wire logic [31:0] bus_rdata,
    input wire logic        debug_halt,
    input wire logic        half_b_capture_pin,
    input wire logic        half_a_pwm_raw,
    input wire logic        half_a_trigger_raw,
    input wire logic        half_a_pwm_out,
    input wire logic        adc_trigger,
    input wire logic        half_b_capture_event,
    input wire logic        half_b_count_enable,
    input wire logic        half_b_capture_enable,
    input wire logic        split_halves
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] c_reg;
    logic       s_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow copies of bits 11:5 and the split bit, rebuilt from bus writes alone.
    always @(posedge clk) begin
        if (rst) c_reg <= 7'h00;
        else if (bus_write && bus_addr == 8'h0c) c_reg <= bus_wdata[11:5];
        if (rst) s_reg <= 1'h0;
        else if (bus_write && bus_addr == 8'h00) s_reg <= bus_wdata[2];
    end
    // Four samples cover the two synchroniser stages and the output register.
    sequence halt_stall;
        (c_reg[4] && debug_halt)[*4];
    endsequence
    // Low then high on the pin, sampled on two edges in a row.
    sequence pin_rise;
        !half_b_capture_pin ##1 half_b_capture_pin;
    endsequence
    // Positive-edge capture with half B running, split and free of stall.
    sequence pos_cfg;
        c_reg[6:5] == 2'h0 && c_reg[3] && !c_reg[4] && s_reg;
    endsequence
    AST_EDGE_POS: assert property (pin_rise ##2 pos_cfg |=> half_b_capture_event)
        else $error("rising capture edge missed");
    AST_EDGE_RSVD: assert property ((c_reg[6:5] == 2'h2 || !c_reg[3] || !s_reg) |=> !half_b_capture_event)
        else $error("capture event while capture is off");
    AST_STALL: assert property (halt_stall |-> !half_b_count_enable)
        else $error("half b counts while stalled");
    AST_RUN_OFF: assert property (!c_reg[3] |=> !half_b_count_enable)
        else $error("half b counts while disabled");
    AST_CAP_EN: assert property (!$past(rst) |-> half_b_capture_enable == $past(c_reg[3] && s_reg))
        else $error("capture enable wrong");
    AST_SPLIT: assert property (!$past(rst) |-> split_halves == $past(s_reg))
        else $error("split flag wrong");
    AST_PWM: assert property (!$past(rst) |-> half_a_pwm_out == ($past(half_a_pwm_raw) ^ $past(c_reg[1])))
        else $error("pwm level wrong");
    AST_TRIG: assert property (!$past(rst) |-> adc_trigger == ($past(half_a_trigger_raw) && $past(c_reg[0])))
        else $error("converter trigger wrong");
    AST_RD_CTL: assert property (bus_read && bus_addr == 8'h0c |=>
        bus_rdata == {20'h0, $past(c_reg[6:3]), 1'h0, $past(c_reg[1:0]), 5'h0})
        else $error("control read wrong");
    AST_RD_ZERO: assert property ((!bus_read || bus_addr == 8'h04) |=> bus_rdata == 32'h0)
        else $error("idle read data not zero");
endmodule
bind tcf_timer_control tcf_timer_control_checker u_tcf_timer_control_checker (.*);

// ### test/tcf_timer_control_test.sv
module tcf_timer_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, rst = 1'h1, bus_write = 1'h0, bus_read = 1'h0, debug_halt = 1'h0;
    logic        cap_pin = 1'h0, pwm_raw = 1'h0, trig_raw = 1'h0;
    logic        pwm_out, adc_trig, cap_evt, cnt_en, cap_en, split;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0, bus_rdata, d;
    int          seed = 19, fails = 0, num_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    tcf_timer_control u_tcf_timer_control (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .debug_halt(debug_halt),
        .half_b_capture_pin(cap_pin), .half_a_pwm_raw(pwm_raw), .half_a_trigger_raw(trig_raw),
        .half_a_pwm_out(pwm_out), .adc_trigger(adc_trig), .half_b_capture_event(cap_evt),
        .half_b_count_enable(cnt_en), .half_b_capture_enable(cap_en), .split_halves(split));
    function automatic logic [31:0] ctl_exp(logic [31:0] v);
        return v & 32'h00000f60;
    endfunction
    // Status bits 2:0 from the control word, with the halt level in bit 31 and split in bit 14.
    function automatic logic [31:0] st_exp(logic [31:0] v);
        logic s;
        logic c;
        s = v[14];
        c = v[8] & s;
        return {29'h0, c & ~(v[9] & v[31]), c, s};
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Each strobe is followed by an idle edge so no signal is driven twice in one step.
    task automatic wr(logic [7:0] a, logic [31:0] v);
        bus_write <= 1'h1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        bus_read <= 1'h1;
        bus_addr <= a;
        @(posedge clk);
        bus_read <= 1'h0;
        #1 cmp(bus_rdata, e);
        @(posedge clk);
    endtask
    // The capture event bit follows a random pin, so only bits 2:0 are compared.
    task automatic rd_status(logic [31:0] e);
        bus_read <= 1'h1;
        bus_addr <= 8'h30;
        @(posedge clk);
        bus_read <= 1'h0;
        #1 cmp(bus_rdata & 32'h00000007, e);
        @(posedge clk);
    endtask
    task give_verdict;
        if (fails == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pwm_raw <= 1'($random(seed));
        trig_raw <= 1'($random(seed));
        cap_pin <= 1'($random(seed));
        if (cyc == 3000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rd(8'h0c, 32'h0);
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, 32'h00000f60);
        for (int i = 0; i < 40; i++) begin
            d = $random(seed);
            if (i < 4) d[11:10] = 2'(i);
            debug_halt <= d[31];
            wr(8'h0c, d);
            wr(8'h00, {29'h0, d[14:12]});
            rd(8'h0c, ctl_exp(d));
            rd(8'h00, {29'h0, d[14:12]});
            rd(8'h04, 32'h0);
            rd_status(st_exp(d));
            repeat (4) @(posedge clk);
        end
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        rd(8'h0c, 32'h0);
        give_verdict;
    end
endmodule
